// File: common/pgupd_defs.svh
// Register offsets, field positions, reset values and mode codes of the PWM generator update control.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
`ifndef PGUPD_DEFS_SVH
`define PGUPD_DEFS_SVH

`define PGUPD_OFF_CTRL 8'h00
`define PGUPD_OFF_STAT 8'h04
`define PGUPD_OFF_LDUTY 8'h08
`define PGUPD_OFF_LPER 8'h0C
`define PGUPD_OFF_LPHASE 8'h10
`define PGUPD_OFF_ADUTY 8'h14
`define PGUPD_OFF_APER 8'h18
`define PGUPD_OFF_APHASE 8'h1C

`define PGUPD_CTRL_DSEL 15
`define PGUPD_CTRL_PSEL 14
`define PGUPD_CTRL_HSEL 13
`define PGUPD_CTRL_BCAST 11
`define PGUPD_CTRL_MODE_HI 10
`define PGUPD_CTRL_MODE_LO 8
`define PGUPD_CTRL_TRGB 6
`define PGUPD_CTRL_SRC_HI 3
`define PGUPD_CTRL_SRC_LO 0
`define PGUPD_CTRL_WMASK 16'hEF4F
`define PGUPD_CTRL_RST 16'h0000
`define PGUPD_VAL_RST 16'h0000

`define PGUPD_STAT_UPD 0
`define PGUPD_STAT_SLV 1

`define PGUPD_MODE_SOC 3'h0
`define PGUPD_MODE_IMM 3'h1
`define PGUPD_MODE_SSOC 3'h2
`define PGUPD_MODE_SIMM 3'h3

`define PGUPD_SRC_SELF 4'h0
`define PGUPD_SRC_GRP_LAST 4'h4

`define PGUPD_RESP_OKAY 2'h0
`define PGUPD_RESP_SLVERR 2'h2

`endif

// File: common/pgupd_pkg.sv
// Types shared by the PWM generator update control and its cycle timer.
// Assumes nothing beyond a SystemVerilog elaborator.
package pgupd_pkg;

	typedef struct packed {
		logic [15:0] duty;
		logic [15:0] period;
		logic [15:0] phase;
	} pgupd_vals_t;

	// Lines shared by the four generators of one group, one bit per generator.
	typedef struct packed {
		logic [3:0] upd_req;
		logic [3:0] eoc;
	} pgupd_grp_t;

	typedef enum logic {
		PGUPD_WST_COLLECT = 1'b0,
		PGUPD_WST_RESP = 1'b1
	} pgupd_wst_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic running;
		logic start;
		logic fin;
	} pgupd_tmr_t;

	typedef struct packed {
		pgupd_wst_t wst;
		logic [7:0] aw_addr;
		logic aw_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic w_held;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] ctrl;
		logic upd_req;
		logic slv_pend;
		logic grp_prev;
		pgupd_vals_t local_v;
		pgupd_vals_t active_v;
		pgupd_vals_t eff_v;
		logic upd_out;
		logic eoc_out;
	} pgupd_state_t;

endpackage

// File: logic/pgupd_cycle_timer.sv
// Cycle timer of one PWM generator: runs the period and marks start and end of each cycle.
// Assumes the external trigger is a one-cycle pulse on CLK_SYS.
`include "pgupd_defs.svh"

module pgupd_cycle_timer
	import pgupd_pkg::*;
#(
	parameter int PER_W = 16
) (
	// Clock, reset and enable.
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic CE,
	// Control.
	input wire logic SELF_RUN,
	input wire logic RETRIG,
	input wire logic TRIG,
	input wire logic [PER_W-1:0] PERIOD,
	// Cycle marks.
	output logic CYCLE_START,
	output logic CYCLE_END,
	output logic [PER_W-1:0] COUNT
);

	pgupd_tmr_t s_ff;
	pgupd_tmr_t nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.start = 1'b0;
		nxt_s.fin = 1'b0;
		if (SELF_RUN) begin
			// Free running: the end of one cycle is the start of the next.
			if (!s_ff.running) begin
				nxt_s.running = 1'b1;
				nxt_s.cnt = '0;
				nxt_s.start = 1'b1;
			end else if (s_ff.cnt >= 16'(PERIOD)) begin
				nxt_s.cnt = '0;
				nxt_s.fin = 1'b1;
				nxt_s.start = 1'b1;
			end else begin
				nxt_s.cnt = s_ff.cnt + 16'h0001;
			end
		end else if (TRIG && (!s_ff.running || RETRIG)) begin
			// A trigger in the middle of a cycle restarts it only when retriggering is chosen.
			nxt_s.running = 1'b1;
			nxt_s.cnt = '0;
			nxt_s.start = 1'b1;
		end else if (s_ff.running) begin
			if (s_ff.cnt >= 16'(PERIOD)) begin
				nxt_s.running = 1'b0;
				nxt_s.fin = 1'b1;
			end else begin
				nxt_s.cnt = s_ff.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			s_ff <= '0;
		end else if (CE) begin
			s_ff <= nxt_s;
		end
	end

	assign CYCLE_START = s_ff.start;
	assign CYCLE_END = s_ff.fin;
	assign COUNT = PER_W'(s_ff.cnt);

endmodule

// File: logic/pgupd_update_ctrl.sv
// Update control of one PWM generator: control-high register, buffered and active values,
// update modes and the update broadcast within a group of four generators.
// Assumes the shared master values come from a common register block on the same clock,
// and that every group line and cycle-start trigger is already on CLK_SYS.
//
// Functional notes
// - Shared duty select picks shared or local duty.
// - Shared period select picks shared or local period.
// - Shared phase select picks shared or local phase.
// - Slaved immediate: load on received master request.
// - Slaved start-of-cycle: load at next cycle start.
// - Immediate mode: load while update request set.
// - Hardware clears update request after the load.
// - Broadcast enabled: send request while update set.
// - Broadcast enabled: share cycle end with group.
// - Requests reach only the own group of four.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`include "pgupd_defs.svh"

module pgupd_update_ctrl
	import pgupd_pkg::*;
#(
	parameter int GEN_INDEX = 0
) (
	// Clock, reset and enable.
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic CE,
	// AXI4-Lite write address and data.
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response.
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read.
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Shared master values and external cycle-start trigger.
	input wire pgupd_vals_t SHARED_VALS,
	input wire logic SOC_TRIG,
	// Group of four.
	input wire pgupd_grp_t GROUP_IN,
	output logic UPD_REQ_OUT,
	output logic EOC_OUT,
	// Values in use and cycle marks.
	output pgupd_vals_t EFF_VALS,
	output logic CYCLE_START,
	output logic CYCLE_END,
	output logic UPD_PENDING
);

	localparam logic [3:0] OWN_MASK = 4'(4'h1 << GEN_INDEX);

	pgupd_state_t s_ff;
	pgupd_state_t nxt_s;

	logic cyc_start;
	logic cyc_end;
	logic self_run;
	logic tmr_trig;
	logic [2:0] mode;
	logic [3:0] src;
	logic [3:0] grp_eoc;
	logic grp_req;
	logic req_rise;
	logic apply;
	logic do_write;
	logic ar_take;

	assign mode = s_ff.ctrl[`PGUPD_CTRL_MODE_HI:`PGUPD_CTRL_MODE_LO];
	assign src = s_ff.ctrl[`PGUPD_CTRL_SRC_HI:`PGUPD_CTRL_SRC_LO];

	// Own lines are masked out, so a generator never answers its own broadcast.
	assign grp_eoc = GROUP_IN.eoc & ~OWN_MASK;
	assign grp_req = |(GROUP_IN.upd_req & ~OWN_MASK);
	assign req_rise = grp_req & ~s_ff.grp_prev;

	// Sources 1 to 4 follow the end of cycle of a group member; higher codes take the external trigger.
	// The external trigger is taken as is, with no synchroniser in between.
	assign self_run = (src == `PGUPD_SRC_SELF);
	always_comb begin
		tmr_trig = SOC_TRIG;
		if (src <= `PGUPD_SRC_GRP_LAST && !self_run) begin
			tmr_trig = grp_eoc[2'(src - 4'h1)];
		end
	end

	pgupd_cycle_timer #(
		.PER_W(16)
	) u_timer (
		.CLK_SYS(CLK_SYS),
		.ARST_N(ARST_N),
		.CE(CE),
		.SELF_RUN(self_run),
		.RETRIG(s_ff.ctrl[`PGUPD_CTRL_TRGB]),
		.TRIG(tmr_trig),
		.PERIOD(s_ff.eff_v.period),
		.CYCLE_START(cyc_start),
		.CYCLE_END(cyc_end),
		.COUNT()
	);

	// Load condition per update mode; reserved codes behave as start-of-cycle.
	always_comb begin
		case (mode)
			`PGUPD_MODE_IMM: apply = s_ff.upd_req;
			`PGUPD_MODE_SSOC: apply = cyc_start & s_ff.slv_pend;
			`PGUPD_MODE_SIMM: apply = s_ff.slv_pend;
			`PGUPD_MODE_SOC: apply = cyc_start & s_ff.upd_req;
			default: apply = cyc_start & s_ff.upd_req;
		endcase
	end

	assign do_write = (s_ff.wst == PGUPD_WST_COLLECT) && s_ff.aw_held && s_ff.w_held;
	assign ar_take = S_AXI_ARVALID && !s_ff.rvalid;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] st);
		logic [15:0] r;
		r = old;
		if (st[0]) begin
			r[7:0] = d[7:0];
		end
		if (st[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	always_comb begin
		nxt_s = s_ff;
		nxt_s.grp_prev = grp_req;

		// Write address and data are collected in either order.
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			nxt_s.aw_held = 1'b1;
			nxt_s.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			nxt_s.w_held = 1'b1;
			nxt_s.w_data = S_AXI_WDATA;
			nxt_s.w_strb = S_AXI_WSTRB;
		end
		if (s_ff.wst == PGUPD_WST_RESP && S_AXI_BREADY) begin
			nxt_s.wst = PGUPD_WST_COLLECT;
		end

		// A master request is remembered until the load it asks for has happened.
		if (req_rise) begin
			nxt_s.slv_pend = 1'b1;
		end
		if (apply) begin
			nxt_s.active_v = s_ff.local_v;
			nxt_s.upd_req = 1'b0;
			nxt_s.slv_pend = req_rise;
		end

		if (do_write) begin
			nxt_s.aw_held = 1'b0;
			nxt_s.w_held = 1'b0;
			nxt_s.wst = PGUPD_WST_RESP;
			nxt_s.bresp = `PGUPD_RESP_OKAY;
			case (s_ff.aw_addr)
				`PGUPD_OFF_CTRL: begin
					nxt_s.ctrl = merge16(s_ff.ctrl, s_ff.w_data, s_ff.w_strb) & `PGUPD_CTRL_WMASK;
				end
				`PGUPD_OFF_STAT: begin
					// Software can only set the request; this set wins over a load in the same cycle.
					if (s_ff.w_strb[0] && s_ff.w_data[`PGUPD_STAT_UPD]) begin
						nxt_s.upd_req = 1'b1;
					end
				end
				`PGUPD_OFF_LDUTY: nxt_s.local_v.duty = merge16(s_ff.local_v.duty, s_ff.w_data, s_ff.w_strb);
				`PGUPD_OFF_LPER: nxt_s.local_v.period = merge16(s_ff.local_v.period, s_ff.w_data, s_ff.w_strb);
				`PGUPD_OFF_LPHASE: nxt_s.local_v.phase = merge16(s_ff.local_v.phase, s_ff.w_data, s_ff.w_strb);
				`PGUPD_OFF_ADUTY, `PGUPD_OFF_APER, `PGUPD_OFF_APHASE: nxt_s.bresp = `PGUPD_RESP_OKAY;
				default: nxt_s.bresp = `PGUPD_RESP_SLVERR;
			endcase
		end

		// Reads answer one cycle after the address is taken.
		if (s_ff.rvalid && S_AXI_RREADY) begin
			nxt_s.rvalid = 1'b0;
		end
		if (ar_take) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = `PGUPD_RESP_OKAY;
			nxt_s.rdata = 32'h0000_0000;
			case (S_AXI_ARADDR)
				`PGUPD_OFF_CTRL: nxt_s.rdata[15:0] = s_ff.ctrl;
				`PGUPD_OFF_STAT: begin
					nxt_s.rdata[`PGUPD_STAT_UPD] = s_ff.upd_req;
					nxt_s.rdata[`PGUPD_STAT_SLV] = s_ff.slv_pend;
				end
				`PGUPD_OFF_LDUTY: nxt_s.rdata[15:0] = s_ff.local_v.duty;
				`PGUPD_OFF_LPER: nxt_s.rdata[15:0] = s_ff.local_v.period;
				`PGUPD_OFF_LPHASE: nxt_s.rdata[15:0] = s_ff.local_v.phase;
				`PGUPD_OFF_ADUTY: nxt_s.rdata[15:0] = s_ff.eff_v.duty;
				`PGUPD_OFF_APER: nxt_s.rdata[15:0] = s_ff.eff_v.period;
				`PGUPD_OFF_APHASE: nxt_s.rdata[15:0] = s_ff.eff_v.phase;
				default: nxt_s.rresp = `PGUPD_RESP_SLVERR;
			endcase
		end

		// Values in use: the shared word replaces the local active word per select bit.
		nxt_s.eff_v.duty = s_ff.ctrl[`PGUPD_CTRL_DSEL] ? SHARED_VALS.duty : s_ff.active_v.duty;
		nxt_s.eff_v.period = s_ff.ctrl[`PGUPD_CTRL_PSEL] ? SHARED_VALS.period : s_ff.active_v.period;
		nxt_s.eff_v.phase = s_ff.ctrl[`PGUPD_CTRL_HSEL] ? SHARED_VALS.phase : s_ff.active_v.phase;

		// The broadcast follows the next request bit, so it drops at the same edge as the own load.
		nxt_s.upd_out = s_ff.ctrl[`PGUPD_CTRL_BCAST] & nxt_s.upd_req;
		nxt_s.eoc_out = s_ff.ctrl[`PGUPD_CTRL_BCAST] & cyc_end;
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			s_ff <= '0;
			s_ff.wst <= PGUPD_WST_COLLECT;
			s_ff.ctrl <= `PGUPD_CTRL_RST;
			s_ff.local_v <= {3{`PGUPD_VAL_RST}};
			s_ff.active_v <= {3{`PGUPD_VAL_RST}};
			s_ff.eff_v <= {3{`PGUPD_VAL_RST}};
		end else if (CE) begin
			s_ff <= nxt_s;
		end
	end

	// Ready only while CE is high, so nothing is taken into frozen state.
	assign S_AXI_AWREADY = CE && !s_ff.aw_held && (s_ff.wst == PGUPD_WST_COLLECT);
	assign S_AXI_WREADY = CE && !s_ff.w_held && (s_ff.wst == PGUPD_WST_COLLECT);
	assign S_AXI_BVALID = (s_ff.wst == PGUPD_WST_RESP);
	assign S_AXI_BRESP = s_ff.bresp;
	assign S_AXI_ARREADY = CE && !s_ff.rvalid;
	assign S_AXI_RVALID = s_ff.rvalid;
	assign S_AXI_RDATA = s_ff.rdata;
	assign S_AXI_RRESP = s_ff.rresp;

	assign UPD_REQ_OUT = s_ff.upd_out;
	assign EOC_OUT = s_ff.eoc_out;
	assign EFF_VALS = s_ff.eff_v;
	assign CYCLE_START = cyc_start;
	assign CYCLE_END = cyc_end;
	assign UPD_PENDING = s_ff.upd_req;

endmodule

// File: verif/pgupd_update_ctrl_assertions.sv
// Port assertions of the PWM generator update control.
// Assumes one clock domain; bound to the design below.
module pgupd_update_ctrl_assertions (
	// Clock and reset.
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	// Register bus.
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Group and cycle marks.
	input wire logic UPD_REQ_OUT,
	input wire logic EOC_OUT,
	input wire logic CYCLE_END,
	input wire logic UPD_PENDING
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!ARST_N);
	sequence s_wtake;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence s_rtake;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	// Both halves are held at the take edge, the write is done one edge later, so the answer shows after two.
	property p_wresp;
		s_wtake |-> ##2 S_AXI_BVALID;
	endproperty
	a_wresp: assert property (p_wresp) else $error("write answer late");
	property p_wblock;
		S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
	endproperty
	a_wblock: assert property (p_wblock) else $error("write taken while answer pending");
	property p_rresp;
		s_rtake |=> S_AXI_RVALID;
	endproperty
	a_rresp: assert property (p_rresp) else $error("read answer late");
	property p_rblock;
		S_AXI_RVALID |-> !S_AXI_ARREADY;
	endproperty
	a_rblock: assert property (p_rblock) else $error("read taken while answer pending");
	property p_rdone;
		S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
	endproperty
	a_rdone: assert property (p_rdone) else $error("read answer not released");
	property p_unmap;
		s_rtake ##0 (S_AXI_ARADDR > 8'h1C) |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read answered wrongly");
	property p_bcast;
		UPD_REQ_OUT |-> UPD_PENDING;
	endproperty
	a_bcast: assert property (p_bcast) else $error("request sent without pending update");
	property p_eoc;
		EOC_OUT |-> $past(CYCLE_END);
	endproperty
	a_eoc: assert property (p_eoc) else $error("cycle end shared without own cycle end");
endmodule

bind pgupd_update_ctrl pgupd_update_ctrl_assertions i_chk (
	.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .UPD_REQ_OUT(UPD_REQ_OUT), .EOC_OUT(EOC_OUT),
	.CYCLE_END(CYCLE_END), .UPD_PENDING(UPD_PENDING)
);

// File: verif/pgupd_group_peer.sv
// Model of the group lines of all four generators, the own line of the bench's generator included.
// Assumes the bench names the members whose request rises.
module pgupd_group_peer
	import pgupd_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Bench command.
	input wire logic [3:0] fire,
	// Group lines.
	output pgupd_grp_t grp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_ff;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 4'h0;
			grp <= '0;
		end else begin
			cnt_ff <= cnt_ff + 4'h1;
			// Requests drop again after a few cycles, so the next one is a fresh edge.
			if (|fire) begin
				grp.upd_req <= fire;
			end else if (cnt_ff[1:0] == 2'h3) begin
				grp.upd_req <= 4'h0;
			end
			grp.eoc <= {2'h0, cnt_ff == 4'hF, 1'b0};
		end
	end
endmodule

// File: verif/pgupd_update_ctrl_tb_top.sv
// Self-checking bench of the PWM generator update control.
// Assumes the group peer model and the bound checker.
module pgupd_update_ctrl_tb_top import pgupd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready, seen_req, seen_eoc;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdat;
	logic [3:0] fire, wstrb, strb;
	logic [1:0] resp;
	pgupd_vals_t shv;
	pgupd_grp_t grp;
	wire logic awready, wready, bvalid, arready, rvalid, upd_req, eoc_out, cstart, pend;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata_w;
	wire pgupd_vals_t eff;
	int n_errors, compares;

	pgupd_update_ctrl #(.GEN_INDEX(0)) i_dut (
		.CLK_SYS(clk), .ARST_N(arst_n), .CE(1'b1), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata_w), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .SHARED_VALS(shv), .SOC_TRIG(1'b0), .GROUP_IN(grp), .UPD_REQ_OUT(upd_req),
		.EOC_OUT(eoc_out), .EFF_VALS(eff), .CYCLE_START(cstart), .CYCLE_END(), .UPD_PENDING(pend)
	);
	pgupd_group_peer i_peer (.clk(clk), .arst_n(arst_n), .fire(fire), .grp(grp));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_req <= 1'b0;
			seen_eoc <= 1'b0;
		end else begin
			if (upd_req) seen_req <= 1'b1;
			if (eoc_out) seen_eoc <= 1'b1;
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	// Handshakes are judged at the falling edge, where the ready lines have settled.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			resp = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			rdat = rdata_w;
			resp = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wait_start;
		@(negedge clk);
		while (!cstart) @(negedge clk);
	endtask
	task automatic pulse(input logic [3:0] f);
		@(posedge clk);
		fire <= f;
		@(posedge clk);
		fire <= 4'h0;
		tick(6);
	endtask

	task automatic t_regs;
		rd(8'h00);
		chk("ctrl reset", 32'h0, rdat);
		rd(8'h04);
		chk("stat reset", 32'h0, rdat);
		wr(8'h00, 16'hFFFF);
		rd(8'h00);
		chk("ctrl mask", 32'h0000EF4F, rdat);
		wr(8'h40, 16'h1234);
		chk("wr unmapped", 32'h2, resp);
		rd(8'h40);
		chk("rd unmapped", 32'h2, resp);
		wr(8'h08, 16'h1234);
		strb = 4'h2;
		wr(8'h08, 16'h56CD);
		strb = 4'hF;
		rd(8'h08);
		chk("strobe lane", 32'h00005634, rdat);
		wr(8'h00, 16'h0100);
		$display("test regs done");
	endtask
	task automatic t_sel;
		wr(8'h08, 16'h000A);
		wr(8'h0C, 16'h0028);
		wr(8'h10, 16'h000C);
		wr(8'h04, 16'h0001);
		for (int s = 0; s < 8; s++) begin
			wr(8'h00, {s[2:0], 13'h0100});
			tick(2);
			chk("duty", s[2] ? shv.duty : 16'h000A, eff.duty);
			chk("period", s[1] ? shv.period : 16'h0028, eff.period);
			chk("phase", s[0] ? shv.phase : 16'h000C, eff.phase);
		end
		$display("test select done");
	endtask
	task automatic t_imm;
		wr(8'h00, 16'h0900);
		wr(8'h08, 16'h0055);
		tick(1);
		chk("imm hold", 32'h000A, eff.duty);
		wr(8'h04, 16'h0001);
		tick(1);
		chk("imm duty", 32'h0055, eff.duty);
		chk("imm clear", 32'h0, pend);
		chk("bcast", 32'h1, seen_req);
		rd(8'h04);
		chk("stat clear", 32'h0, rdat);
		$display("test immediate done");
	endtask
	task automatic t_soc(input logic [2:0] m, input logic [15:0] o, input logic [15:0] d);
		wr(8'h00, {4'h0, 1'b1, m, 8'h00});
		wait_start;
		wr(8'h08, d);
		wr(8'h04, 16'h0001);
		tick(1);
		chk("soc wait", 32'h1, pend);
		chk("soc hold", {16'h0, o}, eff.duty);
		wait_start;
		tick(2);
		chk("soc duty", {16'h0, d}, eff.duty);
		chk("soc clear", 32'h0, pend);
		chk("eoc", 32'h1, seen_eoc);
		$display("test cycle start done");
	endtask
	task automatic t_slv;
		wr(8'h00, 16'h0300);
		wr(8'h08, 16'h0099);
		pulse(4'h1);
		chk("own index", 32'h0066, eff.duty);
		pulse(4'h4);
		chk("slv imm", 32'h0099, eff.duty);
		wr(8'h00, 16'h0200);
		wr(8'h08, 16'h00AA);
		wait_start;
		pulse(4'h2);
		chk("slv wait", 32'h0099, eff.duty);
		wait_start;
		tick(2);
		chk("slv soc", 32'h00AA, eff.duty);
		$display("test slaved done");
	endtask

	task automatic test_done;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		arst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, fire} = '0;
		wstrb = 4'hF;
		strb = 4'hF;
		shv = {16'h1111, 16'h0030, 16'h3333};
		n_errors = 0;
		compares = 0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		t_regs;
		t_sel;
		t_imm;
		t_soc(3'h0, 16'h0055, 16'h0077);
		t_soc(3'h5, 16'h0077, 16'h0066);
		t_slv;
		test_done;
	end
	initial begin
		#50000;
		n_errors++;
		test_done;
	end
endmodule
